/* rtl/aicd_pkg.sv */
// Purpose: shared constants and types of the amplifier control and diagnostic port
// Assumes: two-wire bus pins oversampled by mclk
// Notes:   instruction locations and offset-mode mask used by the port logic
package aicd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // addressing
    localparam logic [6:0] AICD_SLAVE_ADDR = 7'h6c;
    localparam logic [6:0] AICD_LOC_IB1    = 7'h00;
    localparam logic [6:0] AICD_LOC_IB2    = 7'h01;
    localparam int         AICD_SUB_MSB    = 7;

    ////////////////////////////////////////////////////////////////////////////////
    // counters
    localparam logic [2:0] AICD_BIT_FIRST  = 3'h0;
    localparam logic [2:0] AICD_BIT_LAST   = 3'h7;
    localparam logic [2:0] AICD_BIT_ONE    = 3'h1;
    localparam logic [2:0] AICD_BIT_NEXT   = 3'h6;
    localparam logic [1:0] AICD_IDX_FIRST  = 2'h0;
    localparam logic [1:0] AICD_IDX_STAT   = 2'h2;
    localparam logic [1:0] AICD_IDX_ONE    = 2'h1;
    localparam logic [6:0] AICD_PTR_ONE    = 7'h01;

    ////////////////////////////////////////////////////////////////////////////////
    // instruction and report bit positions
    localparam int         AICD_STBY_BIT      = 4;
    localparam int         AICD_DIAG_EN_BIT   = 6;
    localparam int         AICD_STAT_STBY_BIT = 7;
    localparam int         AICD_STAT_DIAG_BIT = 6;
    localparam int         AICD_OFFS_BIT      = 2;
    localparam logic [7:0] AICD_OFFS_MASK     = 8'h26;
    localparam logic [7:0] AICD_IB1_RST       = 8'h00;
    localparam logic [7:0] AICD_IB2_RST       = 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // types
    typedef enum logic [8:0] {
        ST_IDLE  = 9'h001,
        ST_ADDR  = 9'h002,
        ST_ACK   = 9'h004,
        ST_SUB   = 9'h008,
        ST_WDATA = 9'h010,
        ST_RDATA = 9'h020,
        ST_RACK  = 9'h040,
        ST_RNEXT = 9'h080,
        ST_HOLD  = 9'h100
    } aicd_state_e;

    typedef enum logic [1:0] {
        KIND_ADDR = 2'h0,
        KIND_SUB  = 2'h1,
        KIND_DATA = 2'h2
    } aicd_kind_e;

    typedef struct packed {
        logic [7:0] second_instruction_byte;
        logic [7:0] first_instruction_byte;
    } aicd_ctrl_s;

    typedef struct packed {
        logic [7:0] fault_report_byte_4;
        logic [7:0] fault_report_byte_3;
        logic [7:0] fault_report_byte_2;
        logic [7:0] fault_report_byte_1;
    } aicd_diag_s;

endpackage

/* rtl/aicd_sync.sv */
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: synchronous active-high reset; idle bus level is high
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module aicd_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rst,
    // levels
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge clk)
            begin
                if (rst)
                begin
                    meta_q <= 1'b1;
                    sync_q <= 1'b1;
                end
                else
                begin
                    meta_q <= d[i];
                    sync_q <= meta_q;
                end
            end
            assign q[i] = sync_q;
        end
    endgenerate
endmodule
`default_nettype wire

/* rtl/aicd_cond.sv */
// Purpose: clock edges and start/stop conditions of the two-wire bus
// Assumes: inputs already synchronised to clk
// Notes:   outputs are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module aicd_cond (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // synchronised bus lines
    input  wire logic scl,
    input  wire logic sda,
    // events
    output logic      scl_rise,
    output logic      scl_fall,
    output logic      start_det,
    output logic      stop_det
);
    logic scl_p_q;
    logic sda_p_q;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= scl;
            sda_p_q <= sda;
        end
    end

    assign scl_rise  = scl & ~scl_p_q;
    assign scl_fall  = ~scl & scl_p_q;
    // data moving while the clock stays high marks a condition, not a bit
    assign start_det = scl & scl_p_q & sda_p_q & ~sda;
    assign stop_det  = scl & scl_p_q & ~sda_p_q & sda;
endmodule
`default_nettype wire

/* rtl/aicd_port.sv */
// Purpose: two-wire control and diagnostic port of a four-channel amplifier
// Assumes: mclk far faster than the bus clock; pins arrive asynchronously
// Notes:   open-drain data line: sda_o is always low, sda_oe pulls it
// Functional notes
// - answers slave address 1101100, bit0 read/write
// - sub-address MSB clear: write addressed location only
// - sub-address MSB set selects auto-increment
// - auto-increment stores bytes at N, N+1
// - address bit eight set makes a read
// - read data starts after address acknowledge
// - read returns four report bytes in order
// - stray stop in read: keep line until start
// - power-on write stores both instruction bytes
// - power-off write clears stand-by bit
// - offset detection enabled by first byte pattern
// - offset read result valid only in D2
// - data changes only while clock is low
// - stand-by bit mirrored in third report D7
// - diagnostic enable mirrored in third report D6
// - offset mode: D2 shows per-channel offset found
`timescale 1ns/1ps
`default_nettype none
module aicd_port
    import aicd_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // two-wire bus
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // analog diagnostic side
    input  wire aicd_diag_s diag_raw,
    input  wire logic [3:0] offset_found,
    // instruction bytes
    output aicd_ctrl_s      ctrl
);

    ////////////////////////////////////////////////////////////////////////////////
    // pin sampling and bus events

    logic [1:0] pin_s;
    logic       scl_s;
    logic       sda_s;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;

    aicd_sync #(.WIDTH(2)) u_sync (
        .clk (mclk),
        .rst (sys_rst),
        .d   ({scl_i, sda_i}),
        .q   (pin_s)
    );

    assign scl_s = pin_s[1];
    assign sda_s = pin_s[0];

    aicd_cond u_cond (
        .clk       (mclk),
        .rst       (sys_rst),
        .scl       (scl_s),
        .sda       (sda_s),
        .scl_rise  (scl_rise),
        .scl_fall  (scl_fall),
        .start_det (start_det),
        .stop_det  (stop_det)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // report byte assembly

    function automatic logic [7:0] rd_byte(input logic [1:0] idx, input aicd_diag_s raw,
                                           input aicd_ctrl_s c, input logic [3:0] offs);
        logic [7:0] b;
        unique case (idx)
            2'h0:    b = raw.fault_report_byte_1;
            2'h1:    b = raw.fault_report_byte_2;
            2'h2:    b = raw.fault_report_byte_3;
            default: b = raw.fault_report_byte_4;
        endcase
        if (idx == AICD_IDX_STAT)
        begin
            b[AICD_STAT_STBY_BIT] = c.second_instruction_byte[AICD_STBY_BIT];
            b[AICD_STAT_DIAG_BIT] = c.first_instruction_byte[AICD_DIAG_EN_BIT];
        end
        // other bits pass through untouched; software ignores them in this mode
        if ((c.first_instruction_byte & AICD_OFFS_MASK) == AICD_OFFS_MASK)
        begin
            b[AICD_OFFS_BIT] = offs[idx];
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    aicd_state_e state_q,   state_d;
    aicd_kind_e  kind_q,    kind_d;
    logic [2:0]  cnt_q,     cnt_d;
    logic [7:0]  sh_q,      sh_d;
    logic        ack_on_q,  ack_on_d;
    logic        rw_q,      rw_d;
    logic        autoinc_q, autoinc_d;
    logic [6:0]  ptr_q,     ptr_d;
    logic [1:0]  idx_q,     idx_d;
    logic        oe_q,      oe_d;
    aicd_ctrl_s  ctrl_q,    ctrl_d;
    logic        sda_o_q;

    logic [7:0]  byte_in;
    logic [7:0]  rd_cur;
    logic [7:0]  rd_first;
    logic        quiet;
    logic        addr_done;
    logic        addr_hit;
    logic        wr_store;

    assign byte_in   = {sh_q[6:0], sda_s};
    assign rd_cur    = rd_byte(idx_q, diag_raw, ctrl_q, offset_found);
    assign rd_first  = rd_byte(AICD_IDX_FIRST, diag_raw, ctrl_q, offset_found);
    assign quiet     = ~start_det & ~stop_det;
    assign addr_done = quiet & (state_q == ST_ADDR) & scl_rise & (cnt_q == AICD_BIT_LAST);
    assign addr_hit  = addr_done & (byte_in[7:1] == AICD_SLAVE_ADDR);
    assign wr_store  = quiet & (state_q == ST_WDATA) & scl_rise & (cnt_q == AICD_BIT_LAST);

    always_comb
    begin
        state_d   = state_q;
        kind_d    = kind_q;
        cnt_d     = cnt_q;
        sh_d      = sh_q;
        ack_on_d  = ack_on_q;
        rw_d      = rw_q;
        autoinc_d = autoinc_q;
        ptr_d     = ptr_q;
        idx_d     = idx_q;
        oe_d      = oe_q;
        ctrl_d    = ctrl_q;
        if (start_det)
        begin
            state_d  = ST_ADDR;
            cnt_d    = AICD_BIT_FIRST;
            ack_on_d = 1'b0;
            oe_d     = 1'b0;
        end
        else if (stop_det)
        begin
            // a read cut short leaves the line held until the next start
            if (state_q == ST_RDATA || state_q == ST_RACK || state_q == ST_RNEXT)
            begin
                state_d = ST_HOLD;
            end
            else if (state_q != ST_HOLD)
            begin
                state_d = ST_IDLE;
                oe_d    = 1'b0;
            end
        end
        else
        begin
            unique case (state_q)
                ST_IDLE, ST_HOLD:
                begin
                end
                ST_ADDR:
                begin
                    if (scl_rise)
                    begin
                        sh_d  = byte_in;
                        cnt_d = cnt_q + AICD_BIT_ONE;
                        if (cnt_q == AICD_BIT_LAST)
                        begin
                            cnt_d  = AICD_BIT_FIRST;
                            rw_d   = byte_in[0];
                            kind_d = KIND_ADDR;
                            // foreign address: stay off the line until the next start
                            state_d = addr_hit ? ST_ACK : ST_IDLE;
                        end
                    end
                end
                ST_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (!ack_on_q)
                        begin
                            oe_d     = 1'b1;
                            ack_on_d = 1'b1;
                        end
                        else
                        begin
                            ack_on_d = 1'b0;
                            cnt_d    = AICD_BIT_FIRST;
                            if (kind_q == KIND_ADDR && rw_q)
                            begin
                                state_d = ST_RDATA;
                                idx_d   = AICD_IDX_FIRST;
                                oe_d    = ~rd_first[7];
                            end
                            else
                            begin
                                oe_d    = 1'b0;
                                state_d = (kind_q == KIND_ADDR) ? ST_SUB : ST_WDATA;
                            end
                        end
                    end
                end
                ST_SUB:
                begin
                    if (scl_rise)
                    begin
                        sh_d  = byte_in;
                        cnt_d = cnt_q + AICD_BIT_ONE;
                        if (cnt_q == AICD_BIT_LAST)
                        begin
                            cnt_d     = AICD_BIT_FIRST;
                            autoinc_d = byte_in[AICD_SUB_MSB];
                            ptr_d     = byte_in[6:0];
                            kind_d    = KIND_SUB;
                            state_d   = ST_ACK;
                        end
                    end
                end
                ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        sh_d  = byte_in;
                        cnt_d = cnt_q + AICD_BIT_ONE;
                        if (cnt_q == AICD_BIT_LAST)
                        begin
                            cnt_d = AICD_BIT_FIRST;
                            if (ptr_q == AICD_LOC_IB1)
                            begin
                                ctrl_d.first_instruction_byte = byte_in;
                            end
                            else if (ptr_q == AICD_LOC_IB2)
                            begin
                                ctrl_d.second_instruction_byte = byte_in;
                            end
                            if (autoinc_q)
                            begin
                                ptr_d = ptr_q + AICD_PTR_ONE;
                            end
                            kind_d  = KIND_DATA;
                            state_d = ST_ACK;
                        end
                    end
                end
                ST_RDATA:
                begin
                    // drive only on the falling clock so data is stable while high
                    if (scl_fall)
                    begin
                        if (cnt_q == AICD_BIT_LAST)
                        begin
                            oe_d    = 1'b0;
                            cnt_d   = AICD_BIT_FIRST;
                            state_d = ST_RACK;
                        end
                        else
                        begin
                            cnt_d = cnt_q + AICD_BIT_ONE;
                            oe_d  = ~rd_cur[AICD_BIT_NEXT - cnt_q];
                        end
                    end
                end
                ST_RACK:
                begin
                    if (scl_rise)
                    begin
                        if (sda_s)
                        begin
                            state_d = ST_IDLE;
                        end
                        else
                        begin
                            idx_d   = idx_q + AICD_IDX_ONE;
                            state_d = ST_RNEXT;
                        end
                    end
                end
                ST_RNEXT:
                begin
                    if (scl_fall)
                    begin
                        state_d = ST_RDATA;
                        cnt_d   = AICD_BIT_FIRST;
                        oe_d    = ~rd_cur[7];
                    end
                end
                default:
                begin
                    state_d = ST_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (sys_rst)
        begin
            state_q   <= ST_IDLE;
            kind_q    <= KIND_ADDR;
            cnt_q     <= AICD_BIT_FIRST;
            sh_q      <= 8'h00;
            ack_on_q  <= 1'b0;
            rw_q      <= 1'b0;
            autoinc_q <= 1'b0;
            ptr_q     <= 7'h00;
            idx_q     <= AICD_IDX_FIRST;
            oe_q      <= 1'b0;
            ctrl_q    <= {AICD_IB2_RST, AICD_IB1_RST};
            sda_o_q   <= 1'b0;
        end
        else
        begin
            state_q   <= state_d;
            kind_q    <= kind_d;
            cnt_q     <= cnt_d;
            sh_q      <= sh_d;
            ack_on_q  <= ack_on_d;
            rw_q      <= rw_d;
            autoinc_q <= autoinc_d;
            ptr_q     <= ptr_d;
            idx_q     <= idx_d;
            oe_q      <= oe_d;
            ctrl_q    <= ctrl_d;
            sda_o_q   <= 1'b0;
        end
    end

    assign sda_o  = sda_o_q;
    assign sda_oe = oe_q;
    assign ctrl   = ctrl_q;

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_addr_hit;
        addr_hit;
    endsequence

    sequence s_master_ack;
        quiet && state_q == ST_RACK && scl_rise && !sda_s;
    endsequence

    property p_addr_hit;
        s_addr_hit |=> state_q == ST_ACK ##0 !oe_q;
    endproperty
    a_addr_hit: assert property (p_addr_hit) else $error("own address not taken");

    property p_foreign;
        (addr_done && !addr_hit) |=> (state_q == ST_IDLE && !oe_q) [*2];
    endproperty
    a_foreign: assert property (p_foreign) else $error("foreign address answered");

    property p_read_bit;
        (s_addr_hit ##0 byte_in[0]) |=> rw_q;
    endproperty
    a_read_bit: assert property (p_read_bit) else $error("read bit not latched");

    property p_read_after_ack;
        $rose(state_q == ST_RDATA) |-> $past(state_q == ST_ACK || state_q == ST_RNEXT);
    endproperty
    a_read_after_ack: assert property (p_read_after_ack) else $error("read data before acknowledge");

    property p_sda_low_clock;
        $changed(oe_q) |-> $past(scl_fall) || $past(start_det) || $past(stop_det);
    endproperty
    a_sda_low_clock: assert property (p_sda_low_clock) else $error("data line moved with clock high");

    property p_autoinc;
        (wr_store && autoinc_q) |=> ptr_q == $past(ptr_q) + AICD_PTR_ONE;
    endproperty
    a_autoinc: assert property (p_autoinc) else $error("pointer did not advance");

    property p_single;
        (wr_store && !autoinc_q) |=> $stable(ptr_q);
    endproperty
    a_single: assert property (p_single) else $error("pointer moved without auto-increment");

    property p_store_ib2;
        (wr_store && ptr_q == AICD_LOC_IB2) |=> ctrl_q.second_instruction_byte == $past(byte_in);
    endproperty
    a_store_ib2: assert property (p_store_ib2) else $error("second instruction byte not stored");

    property p_stray_stop;
        (stop_det && !start_det && state_q == ST_RDATA) |=> state_q == ST_HOLD && $stable(oe_q);
    endproperty
    a_stray_stop: assert property (p_stray_stop) else $error("line released on stray stop");

    property p_next_byte;
        s_master_ack |=> idx_q == $past(idx_q) + AICD_IDX_ONE ##1 state_q == ST_RNEXT;
    endproperty
    a_next_byte: assert property (p_next_byte) else $error("report byte order broken");

    property p_status_mirror;
        (state_q == ST_RDATA && idx_q == AICD_IDX_STAT)
            |-> rd_cur[AICD_STAT_STBY_BIT] == ctrl_q.second_instruction_byte[AICD_STBY_BIT]
                && rd_cur[AICD_STAT_DIAG_BIT] == ctrl_q.first_instruction_byte[AICD_DIAG_EN_BIT];
    endproperty
    a_status_mirror: assert property (p_status_mirror) else $error("status mirror wrong");

    // checked on the line itself: bit six of the third report byte
    property p_diag_mirror;
        (quiet && state_q == ST_RDATA && idx_q == AICD_IDX_STAT && scl_fall && cnt_q == AICD_BIT_FIRST)
            |=> oe_q == !ctrl_q.first_instruction_byte[AICD_DIAG_EN_BIT];
    endproperty
    a_diag_mirror: assert property (p_diag_mirror) else $error("diagnostic mirror not driven");

    property p_offset_bit;
        ((ctrl_q.first_instruction_byte & AICD_OFFS_MASK) == AICD_OFFS_MASK && state_q == ST_RDATA)
            |-> rd_cur[AICD_OFFS_BIT] == offset_found[idx_q];
    endproperty
    a_offset_bit: assert property (p_offset_bit) else $error("offset result not reported");

endmodule
`default_nettype wire

/* dv/aicd_master.sv */
// Purpose: two-wire bus master model facing the amplifier control port
// Assumes: data line resolved in the bench; the port's drive overrides the master's level
// Notes:   one bus bit is 20 mclk; clock line stands high between frames
`timescale 1ns/1ps
`default_nettype none
module aicd_master (
    // clock
    input  wire logic clk,
    // bus
    input  wire logic sda,
    output logic      scl,
    output logic      sda_drv
);
    ////////////////////////////////////////////////////////////////////////
    initial scl = 1'h1;
    initial sda_drv = 1'h1;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // data set only while clock low, sampled mid-high
    task automatic bitx(input logic b, output logic s);
        sda_drv = b;
        tick(6);
        scl = 1'h1;
        tick(4);
        s = sda;
        tick(4);
        scl = 1'h0;
        tick(6);
    endtask

    task automatic start;
        sda_drv = 1'h1;
        scl = 1'h1;
        tick(8);
        sda_drv = 1'h0;
        tick(8);
        scl = 1'h0;
        tick(4);
    endtask

    // long idle after stop so a new frame never follows too closely
    task automatic stop;
        sda_drv = 1'h0;
        tick(4);
        scl = 1'h1;
        tick(8);
        sda_drv = 1'h1;
        tick(40);
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bitx(d[i], s);
        bitx(1'h1, s);
        ack = ~s;
    endtask

    task automatic rbyte(input logic last, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bitx(1'h1, s);
            d = {d[6:0], s};
        end
        bitx(last, s);
    endtask
endmodule
`default_nettype wire

/* dv/test_amp_i2c_control_diag_port.sv */
// Purpose: self-checking bench of the amplifier control port
// Assumes: master model drives the bus pins
// Notes:   expected bytes follow the report-byte mirroring rules
`timescale 1ns/1ps
`default_nettype none
module test_amp_i2c_control_diag_port;
    import aicd_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    logic       mclk;
    logic       sys_rst;
    logic       scl;
    logic       sda_drv;
    logic       sda;
    logic       sda_o;
    logic       sda_oe;
    logic       ack;
    logic [3:0] offset_found;
    logic [7:0] got [4];
    aicd_diag_s diag_raw;
    aicd_ctrl_s ctrl;
    int         failures;
    int         tests_run;
    int         cycles;

    initial mclk = 1'h0;
    always #5 mclk = ~mclk;
    assign sda = sda_oe ? sda_o : sda_drv;

    aicd_port dut (.mclk(mclk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
                   .sda_oe(sda_oe), .diag_raw(diag_raw), .offset_found(offset_found), .ctrl(ctrl));
    aicd_master m (.clk(mclk), .sda(sda), .scl(scl), .sda_drv(sda_drv));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string what);
        tests_run++;
        if (g !== e)
        begin
            failures++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, g, e);
        end
    endtask

    task automatic wr(input logic [7:0] sub, input logic [7:0] d0, input logic [7:0] d1);
        m.start();
        m.wbyte(8'hd8, ack);
        chk({15'h0, ack}, 16'h1, "write address ack");
        m.wbyte(sub, ack);
        chk({15'h0, ack}, 16'h1, "sub-address ack");
        m.wbyte(d0, ack);
        chk({15'h0, ack}, 16'h1, "first data ack");
        m.wbyte(d1, ack);
        chk({15'h0, ack}, 16'h1, "data ack");
        m.stop();
    endtask

    task automatic rd4;
        m.start();
        m.wbyte(8'hd9, ack);
        chk({15'h0, ack}, 16'h1, "read address ack");
        for (int i = 0; i < 4; i++)
            m.rbyte(i == 3, got[i]);
        m.stop();
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ceiling well above the roughly 6700 cycles the tests take
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            failures++;
            $display("[FAIL] %0t run did not finish", $time);
            summarize();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_rst = 1'h1;
        diag_raw = 32'h5a3c2180;
        offset_found = 4'h5;
        repeat (10) @(posedge mclk);
        #1;
        sys_rst = 1'h0;
        m.tick(6);
        chk(ctrl, 16'h0000, "reset ctrl");
        chk({15'h0, sda_oe}, 16'h0, "reset line");
        chk({15'h0, sda_o}, 16'h0, "open drain level");
        wr(8'h80, 8'h40, 8'h10);
        chk(ctrl, 16'h1040, "auto-increment");
        wr(8'h01, 8'hff, 8'h13);
        chk(ctrl, 16'h1340, "single location");
        $display("test write done");
        rd4();
        chk({8'h0, got[0]}, 16'h0080, "report 1");
        chk({8'h0, got[1]}, 16'h0021, "report 2");
        chk({8'h0, got[2]}, 16'h00fc, "report 3");
        chk({8'h0, got[3]}, 16'h005a, "report 4");
        $display("test read done");
        m.start();
        m.wbyte(8'hda, ack);
        chk({15'h0, ack}, 16'h0, "foreign address");
        m.stop();
        $display("test foreign done");
        wr(8'h80, 8'h26, 8'h10);
        rd4();
        for (int i = 0; i < 4; i++)
            chk({15'h0, got[i][2]}, {15'h0, offset_found[i]}, "offset bit");
        chk({14'h0, got[2][7:6]}, 16'h2, "status mirror");
        wr(8'h81, 8'h00, 8'h00);
        chk(ctrl, 16'h0026, "turn off");
        $display("test offset done");
        m.start();
        m.wbyte(8'hd9, ack);
        chk({15'h0, ack}, 16'h1, "stray read address ack");
        m.stop();
        // clocks without a new start must find the port deaf
        m.rbyte(1'h1, got[0]);
        chk({8'h0, got[0]}, 16'h00ff, "held after stray stop");
        m.stop();
        wr(8'h80, 8'h00, 8'h10);
        chk(ctrl, 16'h1000, "after new start");
        $display("test stray stop done");
        summarize();
    end
endmodule
`default_nettype wire
